// *** pss_pkg.sv ***
// shared constants for the strobed serial pcm port
package pss_pkg;
	// apb register map
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_TXDATA = 8'h04;
	localparam logic [ADDR_W-1:0] REG_RXDATA = 8'h08;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// ctrl pattern field: fifo data, or fixed codes sent instead of fifo data
	localparam logic [1:0] PAT_FIFO = 2'h0;
	localparam logic [1:0] PAT_POS_FS = 2'h1;
	localparam logic [1:0] PAT_POS_ZERO = 2'h2;
	localparam logic [1:0] PAT_NEG_FS = 2'h3;
	// status fields
	localparam int ST_LAW = 0;
	localparam int ST_ASYNC = 1;
	localparam int ST_CSL = 2;
	localparam int ST_EMPTY = 5;
	localparam int ST_FULL = 6;
	localparam int ST_RXVALID = 7;
	localparam int RX_VALID_BIT = 8;
	// code table per law
	localparam logic [7:0] MU_POS_FS = 8'h80;
	localparam logic [7:0] MU_POS_ZERO = 8'hFF;
	localparam logic [7:0] MU_NEG_ZERO = 8'h7F;
	localparam logic [7:0] MU_NEG_FS = 8'h00;
	localparam logic [7:0] A_POS_FS = 8'hAA;
	localparam logic [7:0] A_POS_ZERO = 8'hD5;
	localparam logic [7:0] A_NEG_ZERO = 8'h55;
	localparam logic [7:0] A_NEG_FS = 8'h2A;
	// serial framing
	localparam logic [3:0] BITS_PER_SAMPLE = 4'h8;
	localparam int FIFO_DEPTH = 8;
	localparam int SAMPLE_W = 8;
	// synchronised pin vector layout
	localparam int PIN_W = 11;
	localparam int PIN_LAW = 0;
	localparam int PIN_TXS = 1;
	localparam int PIN_RXS = 2;
	localparam int PIN_CSL = 3;
	localparam int PIN_BCLK = 6;
	localparam int PIN_STB = 7;
	localparam int PIN_DIN = 8;
	localparam int PIN_CCI = 9;
	localparam int PIN_POR = 10;
	// speed select codes and core clock to 512 kHz divide ratios
	localparam logic [2:0] CSL_128K = 3'h4;
	localparam logic [2:0] CSL_256K = 3'h5;
	localparam logic [2:0] CSL_512K = 3'h0;
	localparam logic [2:0] CSL_1536K = 3'h1;
	localparam logic [2:0] CSL_2048K = 3'h2;
	localparam logic [2:0] CSL_4096K = 3'h3;
	localparam logic [3:0] DIV_512K = 4'h1;
	localparam logic [3:0] DIV_1536K = 4'h3;
	localparam logic [3:0] DIV_2048K = 4'h4;
	localparam logic [3:0] DIV_4096K = 4'h8;
endpackage

// *** pss_fifo_if.sv ***
// transmit sample fifo connection between port logic and fifo
`timescale 1ns/1ps
interface pss_fifo_if #(parameter int WIDTH = 8);
	logic push_valid;
	logic push_ready;
	logic [WIDTH-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [WIDTH-1:0] pop_data;
	logic flush;
	modport prod (output push_valid, push_data, pop_ready, flush,
		input push_ready, pop_valid, pop_data);
	modport fifo (input push_valid, push_data, pop_ready, flush,
		output push_ready, pop_valid, pop_data);
endinterface

// *** pss_fifo.sv ***
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module pss_fifo
	import pss_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// fifo ports
	pss_fifo_if.fifo f
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [PW:0] cnt;
	} pss_fifo_s;
	pss_fifo_s s;
	pss_fifo_s next_s;
	logic [WIDTH-1:0] mem [DEPTH];
	logic do_push;
	logic do_pop;

	assign f.push_ready = (s.cnt != (PW+1)'(DEPTH));
	assign f.pop_valid = (s.cnt != '0);
	assign f.pop_data = mem[s.rd];
	assign do_push = f.push_valid && f.push_ready && !f.flush;
	assign do_pop = f.pop_ready && f.pop_valid && !f.flush;

	always_comb
	begin
		next_s = s;
		if (f.flush)
		begin
			next_s = '0;
		end
		else
		begin
			if (do_push)
				next_s.wr = (s.wr == PW'(DEPTH-1)) ? '0 : s.wr + 1'b1;
			if (do_pop)
				next_s.rd = (s.rd == PW'(DEPTH-1)) ? '0 : s.rd + 1'b1;
			next_s.cnt = s.cnt + (PW+1)'(do_push) - (PW+1)'(do_pop);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			s <= '0;
		else
			s <= next_s;
		if (do_push)
			mem[s.wr] <= f.push_data;
	end
endmodule

// *** pss_serial_port.sv ***
// strobed serial pcm port with apb registers and sample fifo
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - reset pin low clears port state but not the apb response; tick still pulses at divide ratio 1
// - law pin high A-law, low mu-law
// - codes follow the selected law's table
// - transmit silence sends negative zero code
// - one 8-bit sample per frame each way
// - output bits change on bit clock rise
// - input bits captured on bit clock fall
// - speed pins set rate and divide ratio
// - speed code map, low rates use 4096
// - receive silence substitutes the quiet code
// - data output released outside the strobe
// - async rates add exactly one frame
module pss_serial_port
	import pss_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// straps and controls
	input wire logic power_up_reset_n,
	input wire logic a_law_select,
	input wire logic transmit_silence,
	input wire logic receive_silence,
	input wire logic clock_speed_sel_0,
	input wire logic clock_speed_sel_1,
	input wire logic clock_speed_sel_2,
	// serial link
	input wire logic bit_clock,
	input wire logic frame_strobe,
	input wire logic core_clock_input,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_out_oe,
	// 512 kHz converter timing pulse
	output logic filter_clock_tick
);
	typedef struct packed {
		logic [PIN_W-1:0] pin_m;
		logic [PIN_W-1:0] pin_s;
		logic bclk_d;
		logic cci_d;
		logic in_slot;
		logic [3:0] tx_cnt;
		logic [3:0] rx_cnt;
		logic [7:0] tx_word;
		logic [7:0] tx_shift;
		logic [7:0] tx_stage;
		logic [7:0] rx_shift;
		logic [7:0] rx_hold;
		logic rx_hold_full;
		logic [7:0] rx_data;
		logic rx_valid;
		logic dout;
		logic dout_oe;
		logic [3:0] div_cnt;
		logic tick;
		logic [1:0] pattern;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} pss_port_s;

	pss_port_s s;
	pss_port_s next_s;
	pss_fifo_if #(.WIDTH(SAMPLE_W)) fq ();

	function automatic logic [7:0] quiet_code(input logic a_law);
		return a_law ? A_NEG_ZERO : MU_NEG_ZERO;
	endfunction

	function automatic logic [3:0] div_ratio(input logic [2:0] csl);
		logic [3:0] r;
		r = DIV_512K;
		unique case (csl)
			CSL_128K, CSL_256K, CSL_4096K: r = DIV_4096K;
			CSL_1536K: r = DIV_1536K;
			CSL_2048K: r = DIV_2048K;
			default: r = DIV_512K;
		endcase
		return r;
	endfunction

	pss_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.f(fq.fifo)
	);

	logic por_ok;
	logic law;
	logic [2:0] csl;
	logic async_mode;
	logic stb;
	logic rise;
	logic fall;
	logic start;
	logic rx_done;
	logic publish;
	logic acc;
	logic done;
	logic blocked;
	logic mapped;
	logic [7:0] new_word;
	logic [7:0] send_word;
	logic [7:0] pub_word;
	logic [31:0] rd_mux;

	assign por_ok = s.pin_s[PIN_POR];
	assign law = s.pin_s[PIN_LAW];
	assign csl = s.pin_s[PIN_CSL +: 3];
	assign async_mode = csl[2];
	assign stb = s.pin_s[PIN_STB];
	assign rise = s.pin_s[PIN_BCLK] && !s.bclk_d;
	assign fall = !s.pin_s[PIN_BCLK] && s.bclk_d;
	assign start = por_ok && rise && stb && !s.in_slot;
	assign rx_done = por_ok && fall && s.in_slot
		&& (s.rx_cnt == BITS_PER_SAMPLE - 4'h1);
	assign publish = rx_done && !async_mode
		|| start && async_mode && s.rx_hold_full;
	assign acc = psel && penable && !s.pready;
	assign done = psel && penable && s.pready;
	assign blocked = pwrite && (paddr == REG_TXDATA) && !fq.push_ready;
	assign mapped = (paddr == REG_CTRL) || (paddr == REG_TXDATA)
		|| (paddr == REG_RXDATA) || (paddr == REG_STATUS);

	assign fq.push_valid = done && pwrite && (paddr == REG_TXDATA);
	assign fq.push_data = pwdata[SAMPLE_W-1:0];
	assign fq.pop_ready = start && (s.pattern == PAT_FIFO);
	assign fq.flush = !por_ok;

	assign pready = s.pready;
	assign prdata = s.prdata;
	assign pslverr = s.pslverr;
	assign serial_data_out = s.dout;
	assign serial_data_out_oe = s.dout_oe;
	assign filter_clock_tick = s.tick;

	//////////////////////////////////////////////////////////////////////////
	// transmit and receive word selection
	always_comb
	begin
		new_word = quiet_code(law);
		unique case (s.pattern)
			PAT_FIFO: if (fq.pop_valid) new_word = fq.pop_data;
			PAT_POS_FS: new_word = law ? A_POS_FS : MU_POS_FS;
			PAT_POS_ZERO: new_word = law ? A_POS_ZERO : MU_POS_ZERO;
			PAT_NEG_FS: new_word = law ? A_NEG_FS : MU_NEG_FS;
		endcase
		if (s.pin_s[PIN_TXS])
			new_word = quiet_code(law);
		send_word = async_mode ? s.tx_stage : new_word;
		pub_word = async_mode ? s.rx_hold : {s.rx_shift[6:0], s.pin_s[PIN_DIN]};
		if (s.pin_s[PIN_RXS])
			pub_word = quiet_code(law);
	end

	//////////////////////////////////////////////////////////////////////////
	// register read mux
	always_comb
	begin
		rd_mux = '0;
		unique case (paddr)
			REG_CTRL: rd_mux[1:0] = s.pattern;
			REG_RXDATA: rd_mux[RX_VALID_BIT:0] = {s.rx_valid, s.rx_data};
			REG_STATUS:
			begin
				rd_mux[ST_LAW] = law;
				rd_mux[ST_ASYNC] = async_mode;
				rd_mux[ST_CSL +: 3] = csl;
				rd_mux[ST_EMPTY] = !fq.pop_valid;
				rd_mux[ST_FULL] = !fq.push_ready;
				rd_mux[ST_RXVALID] = s.rx_valid;
			end
			default: rd_mux = '0;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		next_s = s;
		next_s.pin_m = {power_up_reset_n, core_clock_input, serial_data_in,
			frame_strobe, bit_clock, clock_speed_sel_2, clock_speed_sel_1,
			clock_speed_sel_0, receive_silence, transmit_silence,
			a_law_select};
		next_s.pin_s = s.pin_m;
		next_s.bclk_d = s.pin_s[PIN_BCLK];
		next_s.cci_d = s.pin_s[PIN_CCI];
		next_s.tick = 1'b0;
		// apb slave, one wait state, more while a txdata write finds the fifo full
		if (acc)
		begin
			next_s.pready = !blocked;
			next_s.prdata = rd_mux;
			next_s.pslverr = !mapped;
		end
		else
		begin
			next_s.pready = 1'b0;
		end
		if (done && pwrite && paddr == REG_CTRL)
			next_s.pattern = pwdata[1:0];
		if (done && !pwrite && paddr == REG_RXDATA)
			next_s.rx_valid = 1'b0;
		// core clock divider to the 512 kHz tick
		if (s.pin_s[PIN_CCI] && !s.cci_d)
		begin
			if (s.div_cnt >= div_ratio(csl) - 4'h1)
			begin
				next_s.div_cnt = '0;
				next_s.tick = 1'b1;
			end
			else
			begin
				next_s.div_cnt = s.div_cnt + 4'h1;
			end
		end
		// serial slot
		next_s.dout_oe = stb && s.in_slot || start;
		if (!stb)
			next_s.in_slot = 1'b0;
		if (start)
		begin
			next_s.in_slot = 1'b1;
			next_s.tx_word = send_word;
			next_s.tx_stage = new_word;
			next_s.dout = send_word[7];
			next_s.tx_shift = {send_word[6:0], 1'b0};
			next_s.tx_cnt = 4'h1;
			next_s.rx_cnt = '0;
		end
		else if (rise && s.in_slot && stb && s.tx_cnt < BITS_PER_SAMPLE)
		begin
			next_s.dout = s.tx_shift[7];
			next_s.tx_shift = {s.tx_shift[6:0], 1'b0};
			next_s.tx_cnt = s.tx_cnt + 4'h1;
		end
		if (fall && s.in_slot && s.rx_cnt < BITS_PER_SAMPLE)
		begin
			next_s.rx_shift = {s.rx_shift[6:0], s.pin_s[PIN_DIN]};
			next_s.rx_cnt = s.rx_cnt + 4'h1;
		end
		if (rx_done && async_mode)
		begin
			next_s.rx_hold = {s.rx_shift[6:0], s.pin_s[PIN_DIN]};
			next_s.rx_hold_full = 1'b1;
		end
		else if (publish)
		begin
			next_s.rx_hold_full = 1'b0;
		end
		if (publish)
		begin
			next_s.rx_data = pub_word;
			next_s.rx_valid = 1'b1;
		end
		if (!por_ok)
		begin
			next_s.in_slot = 1'b0;
			next_s.tx_cnt = '0;
			{next_s.rx_cnt, next_s.rx_shift} = '0;
			{next_s.dout, next_s.tx_word, next_s.tx_shift} = '0;
			next_s.dout_oe = 1'b0;
			next_s.tx_stage = '0;
			{next_s.rx_hold_full, next_s.rx_hold} = '0;
			{next_s.rx_valid, next_s.rx_data} = '0;
			next_s.div_cnt = '0;
			next_s.pattern = CTRL_RESET;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			s <= '0;
		else
			s <= next_s;
	end

	//////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence seq_start_sync;
		start && !async_mode;
	endsequence

	sequence seq_start_async;
		start && async_mode;
	endsequence

	AST_RESET_CLEAR: assert property (!por_ok |=> !serial_data_out_oe
		&& s.tx_cnt == 4'h0 && !s.rx_valid)
		else $error("port state not cleared while reset pin low");
	AST_QUIET_TX: assert property (seq_start_sync ##0 s.pin_s[PIN_TXS]
		|=> s.tx_word == quiet_code($past(law)))
		else $error("muted transmit did not send negative zero");
	AST_LAW_FS: assert property (seq_start_sync
		##0 (s.pattern == PAT_POS_FS && !s.pin_s[PIN_TXS])
		|=> s.tx_word == ($past(law) ? A_POS_FS : MU_POS_FS))
		else $error("full scale code wrong for selected law");
	AST_MSB_FIRST: assert property (start
		|=> serial_data_out == s.tx_word[7] && serial_data_out_oe)
		else $error("first bit out is not the msb");
	AST_OE_SLOT: assert property (!stb && !start |=> !serial_data_out_oe)
		else $error("output driven outside the strobe");
	AST_RX_CAPTURE: assert property (fall && s.in_slot
		&& s.rx_cnt < BITS_PER_SAMPLE && por_ok
		|=> s.rx_shift[0] == $past(s.pin_s[PIN_DIN])
		&& s.rx_cnt == $past(s.rx_cnt) + 4'h1)
		else $error("receive bit not captured on falling edge");
	AST_RX_SILENCE: assert property (publish && s.pin_s[PIN_RXS]
		|=> s.rx_data == quiet_code($past(law)) && s.rx_valid)
		else $error("receive silence did not give quiet code");
	AST_ASYNC_DELAY: assert property (seq_start_async
		|=> s.tx_word == $past(s.tx_stage))
		else $error("async transmit skipped the frame delay");
	AST_SYNC_NODELAY: assert property (rx_done && !async_mode
		|=> s.rx_valid && !s.rx_hold_full)
		else $error("sync receive sample delayed");
	AST_TICK_RATIO: assert property (s.pin_s[PIN_CCI] && !s.cci_d
		&& s.div_cnt == div_ratio(csl) - 4'h1 && por_ok
		|=> filter_clock_tick ##1 !filter_clock_tick)
		else $error("converter tick missing at divide ratio");
endmodule

// *** pss_link_model.sv ***
// far-end layer-1 partner: bit clock, strobe and serial data
`timescale 1ns/1ps
module pss_link_model
(
	// link outputs
	output logic bit_clock,
	output logic frame_strobe,
	output logic serial_data_in,
	// device data output
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe
);
	initial
	begin
		bit_clock = 1'b0;
		frame_strobe = 1'b0;
		serial_data_in = 1'b0;
	end
	// one slot of 400 ns bits; clock stands still between slots
	task automatic frame(input logic [7:0] tx, output logic [7:0] rx,
		output logic oe_all);
		oe_all = 1'b1;
		// keep link edges away from the core clock edges
		#10;
		for (int i = 7; i >= 0; i--)
		begin
			bit_clock = 1'b1;
			frame_strobe = 1'b1;
			serial_data_in = tx[i];
			#200 bit_clock = 1'b0;
			// output bit is taken just before the next rise
			// an undriven line reads as the inverse of the last bit
			#180 rx[i] = serial_data_out_oe ? serial_data_out
				: ~serial_data_out;
			oe_all = oe_all & serial_data_out_oe;
			#20;
		end
		frame_strobe = 1'b0;
		// released line shows the inverse, not the last bit
		serial_data_in = ~serial_data_in;
	endtask
endmodule

// *** pss_serial_port_tb.sv ***
// self-checking bench for the strobed serial pcm port
`timescale 1ns/1ps
module pss_serial_port_tb;
	import pss_pkg::*;
	typedef struct packed {
		logic law;
		logic [1:0] pat;
		logic txs;
		logic rxs;
		logic [7:0] smp;
		logic [7:0] tx_exp;
		logic [8:0] rx_exp;
	} pss_row_s;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = '0;
	logic pready, pslverr, dout, oe, tick, bclk, stb, din;
	logic [31:0] prdata, rdat;
	logic por_n = 1'b1;
	logic law = 1'b0;
	logic txs = 1'b0;
	logic rxs = 1'b0;
	logic cci = 1'b0;
	logic [2:0] csl = 3'h0;
	logic [7:0] got;
	logic oe_all, slv;
	pss_row_s r;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int ticks = 0;
	pss_row_s rows [9] = '{
		'{1'b0, 2'h1, 1'b0, 1'b0, 8'h81, 8'h80, 9'h17E},
		'{1'b1, 2'h1, 1'b0, 1'b0, 8'h00, 8'hAA, 9'h1FF},
		'{1'b0, 2'h2, 1'b0, 1'b1, 8'h00, 8'hFF, 9'h17F},
		'{1'b1, 2'h2, 1'b0, 1'b1, 8'h00, 8'hD5, 9'h155},
		'{1'b0, 2'h3, 1'b0, 1'b0, 8'h0F, 8'h00, 9'h1F0},
		'{1'b1, 2'h3, 1'b0, 1'b0, 8'h96, 8'h2A, 9'h169},
		'{1'b0, 2'h0, 1'b0, 1'b0, 8'h3C, 8'h3C, 9'h1C3},
		'{1'b1, 2'h0, 1'b1, 1'b0, 8'h3C, 8'h55, 9'h1C3},
		'{1'b0, 2'h0, 1'b1, 1'b0, 8'hA5, 8'h7F, 9'h15A}};
	logic [2:0] tk_csl [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
	int tk_n [6] = '{1, 3, 4, 8, 8, 8};

	always #25 core_clk = ~core_clk;
	initial
	begin
		#10;
		forever #125 cci = ~cci;
	end
	always @(posedge core_clk)
	begin
		cyc++;
		if (tick === 1'b1)
			ticks++;
		if (cyc == 20000)
		begin
			err_count++;
			finish_test();
		end
	end

	pss_serial_port DUT (
		.core_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata,
		.pready, .prdata, .pslverr,
		.power_up_reset_n(por_n), .a_law_select(law),
		.transmit_silence(txs), .receive_silence(rxs),
		.clock_speed_sel_0(csl[0]), .clock_speed_sel_1(csl[1]),
		.clock_speed_sel_2(csl[2]), .bit_clock(bclk),
		.frame_strobe(stb), .core_clock_input(cci),
		.serial_data_in(din), .serial_data_out(dout),
		.serial_data_out_oe(oe), .filter_clock_tick(tick));
	pss_link_model LNK (.bit_clock(bclk), .frame_strobe(stb),
		.serial_data_in(din), .serial_data_out(dout),
		.serial_data_out_oe(oe));

	////////////////////////////////////////
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
		end
		while (pready !== 1'b1);
		rdat = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic slot(input logic [7:0] d);
		LNK.frame(d, got, oe_all);
		repeat (10) @(posedge core_clk);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge core_clk);
		check({28'h0, pready, pslverr, oe, tick}, 32'h0);
		sys_rst <= 1'b0;
		foreach (rows[i])
		begin
			r = rows[i];
			@(posedge core_clk);
			law <= r.law;
			txs <= r.txs;
			rxs <= r.rxs;
			wr(REG_CTRL, {30'h0, r.pat});
			if (r.pat == PAT_FIFO)
				wr(REG_TXDATA, {24'h0, r.smp});
			repeat (4) @(posedge core_clk);
			slot(~r.smp);
			check({24'h0, got}, {24'h0, r.tx_exp});
			check({31'h0, oe_all}, 32'h1);
			check({31'h0, oe}, 32'h0);
			rd(REG_RXDATA);
			check(rdat, {23'h0, r.rx_exp});
		end
		rd(8'h10);
		check({31'h0, slv}, 32'h1);
		check(rdat, 32'h0);
		txs <= 1'b0;
		wr(REG_CTRL, 32'h0);
		for (int i = 0; i < FIFO_DEPTH; i++)
			wr(REG_TXDATA, 32'h10 + i);
		rd(REG_STATUS);
		check({30'h0, rdat[ST_FULL], rdat[ST_EMPTY]}, 32'h2);
		// write into a full fifo waits until a slot pops a word
		fork
			wr(REG_TXDATA, 32'h18);
			slot(8'h00);
		join
		check({24'h0, got}, 32'h10);
		for (int i = 1; i <= FIFO_DEPTH; i++)
		begin
			slot(8'h00);
			check({24'h0, got}, 32'h10 + i);
		end
		rd(REG_STATUS);
		check({30'h0, rdat[ST_FULL], rdat[ST_EMPTY]}, 32'h1);
		@(posedge core_clk);
		csl <= CSL_128K;
		por_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		por_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(REG_STATUS);
		check(rdat, 32'h32);
		wr(REG_TXDATA, 32'h11);
		wr(REG_TXDATA, 32'h22);
		slot(8'h5A);
		check({24'h0, got}, 32'h0);
		rd(REG_RXDATA);
		check(rdat, 32'h0);
		slot(8'hC3);
		check({24'h0, got}, 32'h11);
		rd(REG_RXDATA);
		check(rdat, 32'h15A);
		foreach (tk_csl[i])
		begin
			@(posedge core_clk);
			csl <= tk_csl[i];
			repeat (20) @(posedge core_clk);
			ticks = 0;
			repeat (480) @(posedge core_clk);
			check(32'(ticks >= 96 / tk_n[i] - 1 && ticks <= 96 / tk_n[i] + 1),
				32'h1);
		end
		finish_test();
	end
endmodule
